// ===== core/marker_command_box_io.sv
// Command box discrete I/O: contact inputs, start/stop pulses and status outputs
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module marker_command_box_io
   import marker_io_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_clock_enable,
   input wire logic [ADDR_W-1:0] i_address,
   input wire logic [DATA_W-1:0] i_write_data,
   input wire logic i_write_strobe,
   input wire logic i_read_strobe,
   output logic [DATA_W-1:0] o_read_data,
   input wire logic i_primary_enable_in,
   input wire logic i_secondary_enable_in,
   input wire logic i_key_switch_in,
   input wire logic i_plug_detect_in,
   input wire logic i_start_in,
   input wire logic i_stop_in,
   input wire logic i_muting_plug_in,
   output logic o_busy_out,
   output logic o_end_of_job_out,
   output logic o_warmed_up_out,
   output logic o_alarm_out,
   output logic o_emission_ready_out,
   output logic o_job_armed_out,
   output logic o_interrupt
);

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_level;
   logic [PIN_W-1:0] pins_prev_r;
   logic start_edge;
   logic stop_edge;

   assign pins_raw = {i_muting_plug_in, i_stop_in, i_start_in, i_plug_detect_in,
                      i_key_switch_in, i_secondary_enable_in, i_primary_enable_in};

   pin_filter #(
      .WIDTH(PIN_W)
   ) u_pin_filter (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_clock_enable(i_clock_enable),
      .i_pins(pins_raw),
      .o_level(pins_level)
   );

   // Previous filtered levels for edge detection
   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
         pins_prev_r <= '0;
      else if (i_clock_enable)
         pins_prev_r <= pins_level;
   end

   assign start_edge = pins_level[PIN_START] & ~pins_prev_r[PIN_START];
   assign stop_edge = pins_level[PIN_STOP] & ~pins_prev_r[PIN_STOP];

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   logic [DATA_W-1:0] control_r;
   logic legacy_arm_option;
   run_mode_t production_run_mode;
   laser_state_t laser_state;
   logic doc_running;
   logic script_running;
   logic system_error;
   logic wr_en;
   logic rd_en;

   assign wr_en = i_clock_enable & i_write_strobe;
   assign rd_en = i_clock_enable & i_read_strobe;
   assign legacy_arm_option = control_r[CTL_LEGACY_ARM];
   assign production_run_mode = run_mode_t'(control_r[CTL_MODE_HI:CTL_MODE_LO]);
   assign doc_running = control_r[CTL_DOC_RUNNING];
   assign script_running = control_r[CTL_SCRIPT_RUNNING];
   assign laser_state = laser_state_t'(control_r[CTL_LASER_HI:CTL_LASER_LO]);
   assign system_error = control_r[CTL_SYS_ERROR];

   // Software-held mode and system state; unused bits stay zero
   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
         control_r <= CONTROL_RESET;
      else if (wr_en && i_address == ADDR_CONTROL)
         control_r <= {{(DATA_W-CTL_USED_W){1'b0}}, i_write_data[CTL_USED_W-1:0]};
   end

   // ----------------------------------------
   // Qualifiers
   // ----------------------------------------
   logic enable_ok;
   logic auto_or_prod;
   logic job_context;
   logic start_ok;
   logic abort;
   logic finish_cmd;
   logic arm_set_cmd;
   logic arm_clear_cmd;

   assign enable_ok = pins_level[PIN_MUTING] |
                      (pins_level[PIN_PRIMARY] & pins_level[PIN_SECONDARY] & pins_level[PIN_KEY]);

   assign auto_or_prod = (production_run_mode == MODE_AUTO) || (production_run_mode == MODE_PRODUCTION);
   assign job_context = doc_running & auto_or_prod;

   // start gated by run context, stop has priority
   assign start_ok = start_edge & ~stop_edge & job_context & pins_level[PIN_PLUG] & enable_ok &
                     (laser_state == LASER_READY) & ~system_error;

   // stop pulse or loss of plug/enable ends a job
   assign abort = stop_edge | ~pins_level[PIN_PLUG] | ~enable_ok;

   assign finish_cmd = wr_en & (i_address == ADDR_COMMAND) & i_write_data[CMD_FINISH];
   assign arm_set_cmd = wr_en & (i_address == ADDR_COMMAND) & i_write_data[CMD_ARM_SET];
   assign arm_clear_cmd = wr_en & (i_address == ADDR_COMMAND) & i_write_data[CMD_ARM_CLEAR];

   // ----------------------------------------
   // Job sequencer
   // ----------------------------------------
   job_state_t state_r;
   job_state_t state_nxt;

   // Next job state
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         JOB_IDLE:
         begin
            if (start_ok)
               state_nxt = JOB_MARKING;
         end
         JOB_MARKING:
         begin
            if (abort)
               state_nxt = JOB_IDLE;
            else if (finish_cmd)
               state_nxt = JOB_DONE;
         end
         JOB_DONE:
         begin
            if (start_ok)
               state_nxt = JOB_MARKING;
            else if (stop_edge)
               state_nxt = JOB_IDLE;
         end
         default:
            state_nxt = JOB_IDLE;
      endcase
   end

   // Job state register
   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
         state_r <= JOB_IDLE;
      else if (i_clock_enable)
         state_r <= state_nxt;
   end

   // ----------------------------------------
   // Script arming
   // ----------------------------------------
   logic script_arm_r;

   // set-armed call latched, dropped when the script ends
   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
         script_arm_r <= 1'b0;
      else if (i_clock_enable)
      begin
         if (!script_running || arm_clear_cmd)
            script_arm_r <= 1'b0;
         else if (arm_set_cmd)
            script_arm_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Status outputs, registered
   // ----------------------------------------
   logic armed_nxt;

   // armed condition by option and job kind
   always_comb
   begin
      if (legacy_arm_option)
         armed_nxt = job_context;
      else
         armed_nxt = doc_running & (production_run_mode == MODE_AUTO) & (laser_state == LASER_READY);
      if (script_running && production_run_mode == MODE_AUTO && script_arm_r)
         armed_nxt = 1'b1;
   end

   // Busy and end outputs follow next state so they line up with the job state
   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_busy_out <= 1'b0;
         o_end_of_job_out <= 1'b0;
         o_warmed_up_out <= 1'b0;
         o_alarm_out <= 1'b0;
         o_emission_ready_out <= 1'b0;
         o_job_armed_out <= 1'b0;
      end
      else if (i_clock_enable)
      begin
         o_busy_out <= (state_nxt == JOB_MARKING);
         o_end_of_job_out <= (state_nxt == JOB_DONE);
         o_warmed_up_out <= (laser_state == LASER_WARM_IDLE) || (laser_state == LASER_READY);
         o_alarm_out <= (laser_state == LASER_STARTUP) || system_error;
         o_emission_ready_out <= (laser_state == LASER_READY);
         o_job_armed_out <= armed_nxt;
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   logic [IRQ_W-1:0] irq_status_r;
   logic [IRQ_W-1:0] irq_enable_r;
   logic [IRQ_W-1:0] irq_event;
   logic [IRQ_W-1:0] irq_clear;
   logic plug_prev_r;
   logic enable_prev_r;

   assign irq_event[IRQ_START] = start_ok && state_r != JOB_MARKING;
   assign irq_event[IRQ_STOP] = stop_edge;
   assign irq_event[IRQ_FINISH] = (state_r == JOB_MARKING) && (state_nxt == JOB_DONE);
   assign irq_event[IRQ_PLUG_LOST] = plug_prev_r & ~pins_level[PIN_PLUG];
   assign irq_event[IRQ_ENABLE_LOST] = enable_prev_r & ~enable_ok;
   assign irq_clear = (wr_en && i_address == ADDR_IRQ_CLEAR) ? i_write_data[IRQ_W-1:0] : '0;

   // Previous plug and enable levels for loss events
   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
      begin
         plug_prev_r <= 1'b0;
         enable_prev_r <= 1'b0;
      end
      else if (i_clock_enable)
      begin
         plug_prev_r <= pins_level[PIN_PLUG];
         enable_prev_r <= enable_ok;
      end
   end

   // Sticky status; an event in the clearing cycle is kept
   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
         irq_status_r <= '0;
      else if (i_clock_enable)
         irq_status_r <= (irq_status_r & ~irq_clear) | irq_event;
   end

   // Interrupt enable mask
   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
         irq_enable_r <= '0;
      else if (wr_en && i_address == ADDR_IRQ_ENABLE)
         irq_enable_r <= i_write_data[IRQ_W-1:0];
   end

   assign o_interrupt = |(irq_status_r & irq_enable_r);

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   logic [ST_USED_W-1:0] status_word;

   assign status_word = {enable_ok, pins_level, o_busy_out, o_end_of_job_out, o_job_armed_out,
                         o_warmed_up_out, o_alarm_out, o_emission_ready_out};

   // Data stands one cycle after the read, zero otherwise and when unmapped
   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
         o_read_data <= READ_ZERO;
      else if (i_clock_enable && !i_read_strobe)
         o_read_data <= READ_ZERO;
      else if (rd_en)
      begin
         unique case (i_address)
            ADDR_CONTROL:
               o_read_data <= control_r;
            ADDR_STATUS:
               o_read_data <= {{(DATA_W-ST_USED_W){1'b0}}, status_word};
            ADDR_IRQ_STATUS:
               o_read_data <= {{(DATA_W-IRQ_W){1'b0}}, irq_status_r};
            ADDR_IRQ_ENABLE:
               o_read_data <= {{(DATA_W-IRQ_W){1'b0}}, irq_enable_r};
            default:
               o_read_data <= READ_ZERO;
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_reset);

   // A start seen while marking is ignored, so only idle or done counts
   sequence start_taken_s;
      i_clock_enable && start_ok && state_r != JOB_MARKING;
   endsequence

   sequence stop_seen_s;
      i_clock_enable && stop_edge;
   endsequence

   busy_tracks_job_a: assert property (o_busy_out == (state_r == JOB_MARKING))
      else $error("busy output disagrees with job state");

   start_opens_job_a: assert property (start_taken_s |=> o_busy_out && !o_end_of_job_out)
      else $error("accepted start did not raise busy");

   stop_ends_job_a: assert property (stop_seen_s |=> !o_busy_out)
      else $error("busy still high after stop");

   stop_beats_start_a: assert property (stop_edge |-> !start_ok)
      else $error("start accepted alongside stop");

   finish_raises_end_a: assert property (
      (i_clock_enable && state_r == JOB_MARKING && finish_cmd && !abort) |=> o_end_of_job_out && !o_busy_out)
      else $error("end output missing after finish");

   warmed_output_a: assert property (i_clock_enable |=> o_warmed_up_out ==
      ($past(laser_state) == LASER_WARM_IDLE || $past(laser_state) == LASER_READY))
      else $error("warmed output wrong for laser state");

   alarm_output_a: assert property (i_clock_enable |=> o_alarm_out ==
      ($past(laser_state) == LASER_STARTUP || $past(system_error)))
      else $error("alarm output wrong");

   emission_ready_a: assert property (i_clock_enable |=>
      o_emission_ready_out == ($past(laser_state) == LASER_READY))
      else $error("emission ready output wrong");

   legacy_arm_a: assert property (
      (i_clock_enable && legacy_arm_option && job_context) |=> o_job_armed_out)
      else $error("legacy arming not shown");

   strict_arm_a: assert property (
      (i_clock_enable && !legacy_arm_option && !script_running && laser_state != LASER_READY) |=> !o_job_armed_out)
      else $error("armed without ready laser");

   script_arm_a: assert property (
      (i_clock_enable && script_running && !script_arm_r && !arm_set_cmd && !doc_running) |=> !o_job_armed_out)
      else $error("script armed without set-armed call");

   muting_bypass_a: assert property (pins_level[PIN_MUTING] |-> enable_ok)
      else $error("muting plug did not bypass enable");

   single_edge_a: assert property ((i_clock_enable && start_edge) |=> !start_edge)
      else $error("start edge seen twice");

   plug_loss_a: assert property ((i_clock_enable && !pins_level[PIN_PLUG]) |=> !o_busy_out)
      else $error("marking without plug present");

   // Sticky set beats clear
   irq_set_wins_a: assert property ((i_clock_enable && irq_event[IRQ_STOP]) |=> irq_status_r[IRQ_STOP])
      else $error("stop event lost against clear");

endmodule // marker_command_box_io

`default_nettype wire

// ===== core/marker_io_pkg.sv
// Constants, field layouts and enumerations for the command box I/O block
package marker_io_pkg;

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_COMMAND = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 4'h5;
   localparam logic [DATA_W-1:0] CONTROL_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int CTL_LEGACY_ARM = 0;
   localparam int CTL_MODE_LO = 1;
   localparam int CTL_MODE_HI = 2;
   localparam int CTL_DOC_RUNNING = 3;
   localparam int CTL_SCRIPT_RUNNING = 4;
   localparam int CTL_LASER_LO = 5;
   localparam int CTL_LASER_HI = 6;
   localparam int CTL_SYS_ERROR = 7;
   localparam int CTL_USED_W = 8;

   // ----------------------------------------
   // Command register bits (write-only strobes)
   // ----------------------------------------
   localparam int CMD_FINISH = 0;
   localparam int CMD_ARM_SET = 1;
   localparam int CMD_ARM_CLEAR = 2;

   // ----------------------------------------
   // Status register bits
   // ----------------------------------------
   localparam int ST_EMISSION = 0;
   localparam int ST_ALARM = 1;
   localparam int ST_WARMED = 2;
   localparam int ST_ARMED = 3;
   localparam int ST_END = 4;
   localparam int ST_BUSY = 5;
   localparam int ST_PINS_LO = 6;
   localparam int ST_ENABLE_OK = 13;
   localparam int ST_USED_W = 14;

   // ----------------------------------------
   // Interrupt event bits
   // ----------------------------------------
   localparam int IRQ_START = 0;
   localparam int IRQ_STOP = 1;
   localparam int IRQ_FINISH = 2;
   localparam int IRQ_PLUG_LOST = 3;
   localparam int IRQ_ENABLE_LOST = 4;
   localparam int IRQ_W = 5;

   // ----------------------------------------
   // Synchronised pin vector positions
   // ----------------------------------------
   localparam int PIN_PRIMARY = 0;
   localparam int PIN_SECONDARY = 1;
   localparam int PIN_KEY = 2;
   localparam int PIN_PLUG = 3;
   localparam int PIN_START = 4;
   localparam int PIN_STOP = 5;
   localparam int PIN_MUTING = 6;
   localparam int PIN_W = 7;

   // ----------------------------------------
   // Enumerations
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_MANUAL = 2'h0,
      MODE_AUTO = 2'h1,
      MODE_PRODUCTION = 2'h2,
      MODE_SPARE = 2'h3
   } run_mode_t;

   typedef enum logic [1:0] {
      LASER_STARTUP = 2'h0,
      LASER_WARM_IDLE = 2'h1,
      LASER_READY = 2'h2,
      LASER_OFF = 2'h3
   } laser_state_t;

   typedef enum logic [2:0] {
      JOB_IDLE = 3'b001,
      JOB_MARKING = 3'b010,
      JOB_DONE = 3'b100
   } job_state_t;

endpackage

// ===== core/pin_filter.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_filter #(
   parameter int WIDTH = 1
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_clock_enable,
   input wire logic [WIDTH-1:0] i_pins,
   output logic [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;
   logic [WIDTH-1:0] stage3_r;

   // Shift chain; the first stage feeds only the second
   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
      begin
         stage1_r <= '0;
         stage2_r <= '0;
         stage3_r <= '0;
      end
      else if (i_clock_enable)
      begin
         stage1_r <= i_pins;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
      end
   end

   // A bit changes only once stages two and three agree
   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
         o_level <= '0;
      else if (i_clock_enable)
         o_level <= (stage2_r & stage3_r) | (o_level & (stage2_r | stage3_r));
   end

endmodule // pin_filter

`default_nettype wire

// ===== verif/cmd_box_model.sv
// External controller model driving the command box contact and pulse pins
`timescale 1ns/1ps
`default_nettype none

module cmd_box_model (
   input wire logic i_clock,
   output logic o_primary,
   output logic o_secondary,
   output logic o_key,
   output logic o_plug,
   output logic o_start,
   output logic o_stop,
   output logic o_muting
);
   // ----------------------------------------
   // Contacts and pulses
   // ----------------------------------------
   // Low stands for an open or unplugged contact
   initial {o_muting, o_plug, o_key, o_secondary, o_primary, o_start, o_stop} = 7'h00;

   task automatic contacts(input logic [4:0] lv);
      @(posedge i_clock);
      {o_muting, o_plug, o_key, o_secondary, o_primary} <= lv;
   endtask

   // high pulses
   // Held four cycles so the pin filter sees them
   task automatic pulse(input logic st, input logic sp);
      @(posedge i_clock);
      o_start <= st;
      o_stop <= sp;
      repeat (4) @(posedge i_clock);
      o_start <= 1'b0;
      o_stop <= 1'b0;
      repeat (4) @(posedge i_clock);
   endtask
endmodule // cmd_box_model

`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the command box discrete I/O block
`timescale 1ns/1ps
`default_nettype none

module tb
   import marker_io_pkg::*;
;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic [ADDR_W-1:0] address = 4'h0;
   logic [DATA_W-1:0] wdata = 16'h0000;
   logic we = 1'b0;
   logic re = 1'b0;
   logic ce = 1'b1;
   logic [DATA_W-1:0] rdata;
   logic pri, sec, key, plug, start, stop, mute;
   logic busy, done, warm, alarm, emit, armed, irq;
   logic [15:0] v;
   int miscompares = 0;
   int checked = 0;

   // Clock and reset
   always #10 i_clock = ~i_clock;
   initial
   begin
      repeat (3) @(posedge i_clock);
      i_reset <= 1'b0;
   end

   marker_command_box_io u_marker_command_box_io (.i_clock(i_clock), .i_reset(i_reset), .i_clock_enable(ce),
      .i_address(address), .i_write_data(wdata), .i_write_strobe(we), .i_read_strobe(re), .o_read_data(rdata),
      .i_primary_enable_in(pri), .i_secondary_enable_in(sec), .i_key_switch_in(key), .i_plug_detect_in(plug),
      .i_start_in(start), .i_stop_in(stop), .i_muting_plug_in(mute), .o_busy_out(busy),
      .o_end_of_job_out(done), .o_warmed_up_out(warm), .o_alarm_out(alarm), .o_emission_ready_out(emit),
      .o_job_armed_out(armed), .o_interrupt(irq));

   cmd_box_model u_cmd_box_model (.i_clock(i_clock), .o_primary(pri), .o_secondary(sec), .o_key(key),
      .o_plug(plug), .o_start(start), .o_stop(stop), .o_muting(mute));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic stop_test;
      $display("Comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clock);
      address <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge i_clock);
      we <= 1'b0;
   endtask

   // Data is sampled in the single cycle it stands
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_clock);
      address <= a;
      re <= 1'b1;
      @(posedge i_clock);
      re <= 1'b0;
      #1 d = rdata;
   endtask

   function automatic logic [15:0] ctl(logic lg, logic [1:0] md, logic doc, logic scr, logic [1:0] ls, logic er);
      return {8'h00, er, ls, scr, doc, md, lg};
   endfunction

   task automatic settle;
      repeat (3) @(posedge i_clock);
      #1;
   endtask

   // Order: busy, end, warmed, alarm, emission, armed
   task automatic co(input logic [5:0] e);
      settle;
      chk("outputs", {10'h000, e}, {10'h000, busy, done, warm, alarm, emit, armed});
   endtask

   task automatic wait_busy(input logic e);
      int n;
      n = 0;
      #1;
      while (busy !== e && n < 20)
      begin
         @(posedge i_clock);
         #1;
         n++;
      end
      chk("busy", {15'h0000, e}, {15'h0000, busy});
      // A used-up wait must never end the run as a pass
      if (n == 20)
      begin
         miscompares++;
         stop_test;
      end
   endtask

   task automatic job(input logic st, input logic sp, input logic e);
      u_cmd_box_model.pulse(st, sp);
      wait_busy(e);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      repeat (5) @(posedge i_clock);
      co(6'h04);
      rd(ADDR_CONTROL, v);
      chk("control", CONTROL_RESET, v);
      rd(4'hF, v);
      chk("unmapped", READ_ZERO, v);
   endtask

   task automatic t_laser;
      for (int l = 0; l < 4; l++)
      begin
         wr(ADDR_CONTROL, ctl(1'b0, MODE_AUTO, 1'b0, 1'b0, l[1:0], 1'b0));
         co({2'b00, l == 1 || l == 2, l == 0, l == 2, 1'b0});
      end
      wr(ADDR_CONTROL, ctl(1'b0, MODE_AUTO, 1'b0, 1'b0, LASER_READY, 1'b1));
      co(6'b001110);
   endtask

   task automatic t_job;
      u_cmd_box_model.contacts(5'b01111);
      wr(ADDR_IRQ_ENABLE, 16'h0005);
      wr(ADDR_CONTROL, ctl(1'b0, MODE_PRODUCTION, 1'b1, 1'b0, LASER_READY, 1'b0));
      job(1'b1, 1'b0, 1'b1);
      chk("irq", 16'h0001, {15'h0000, irq});
      wr(ADDR_IRQ_CLEAR, 16'h0001);
      co(6'b101010);
      wr(ADDR_COMMAND, 16'h0001);
      co(6'b011010);
      rd(ADDR_IRQ_STATUS, v);
      chk("irq status", 16'h0004, v);
      wr(ADDR_IRQ_CLEAR, 16'h001F);
      settle;
      chk("irq", 16'h0000, {15'h0000, irq});
      job(1'b1, 1'b0, 1'b1);
      job(1'b0, 1'b1, 1'b0);
      chk("end", 16'h0000, {15'h0000, done});
      job(1'b1, 1'b1, 1'b0);
   endtask

   task automatic t_refuse;
      wr(ADDR_CONTROL, ctl(1'b0, MODE_MANUAL, 1'b1, 1'b0, LASER_READY, 1'b0));
      job(1'b1, 1'b0, 1'b0);
      wr(ADDR_CONTROL, ctl(1'b0, MODE_AUTO, 1'b1, 1'b0, LASER_READY, 1'b0));
      u_cmd_box_model.contacts(5'b01101);
      job(1'b1, 1'b0, 1'b0);
      u_cmd_box_model.contacts(5'b01110);
      job(1'b1, 1'b0, 1'b0);
      u_cmd_box_model.contacts(5'b00111);
      job(1'b1, 1'b0, 1'b0);
      u_cmd_box_model.contacts(5'b11000);
      job(1'b1, 1'b0, 1'b1);
      job(1'b0, 1'b1, 1'b0);
   endtask

   task automatic t_armed;
      wr(ADDR_CONTROL, ctl(1'b1, MODE_PRODUCTION, 1'b1, 1'b0, LASER_WARM_IDLE, 1'b0));
      co(6'b001001);
      wr(ADDR_CONTROL, ctl(1'b0, MODE_PRODUCTION, 1'b1, 1'b0, LASER_READY, 1'b0));
      co(6'b001010);
      wr(ADDR_CONTROL, ctl(1'b0, MODE_AUTO, 1'b1, 1'b0, LASER_READY, 1'b0));
      co(6'b001011);
      wr(ADDR_CONTROL, ctl(1'b0, MODE_AUTO, 1'b1, 1'b0, LASER_WARM_IDLE, 1'b0));
      co(6'b001000);
      wr(ADDR_CONTROL, ctl(1'b0, MODE_AUTO, 1'b0, 1'b1, LASER_READY, 1'b0));
      co(6'b001010);
      wr(ADDR_COMMAND, 16'h0002);
      co(6'b001011);
      wr(ADDR_COMMAND, 16'h0004);
      co(6'b001010);
   endtask

   // Clock enable low freezes outputs and ignores the bus
   task automatic t_freeze;
      @(posedge i_clock);
      ce <= 1'b0;
      wr(ADDR_CONTROL, ctl(1'b0, MODE_AUTO, 1'b0, 1'b0, LASER_STARTUP, 1'b0));
      co(6'b001010);
      @(posedge i_clock);
      ce <= 1'b1;
      co(6'b001010);
      // Muting and plug high, ready laser, nothing armed or marking
      rd(ADDR_STATUS, v);
      chk("status", 16'h3205, v);
      // Start, stop, plug loss and enable loss seen since the last clear
      rd(ADDR_IRQ_STATUS, v);
      chk("irq status", 16'h001B, v);
      rd(ADDR_IRQ_ENABLE, v);
      chk("irq enable", 16'h0005, v);
   endtask

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge i_clock);
      miscompares++;
      stop_test;
   end

   initial
   begin
      t_reset;
      t_laser;
      t_job;
      t_refuse;
      t_armed;
      t_freeze;
      stop_test;
   end
endmodule // tb

`default_nettype wire
